// file: smp_port_regs.vh
// Register map, field positions and reset values of the serial port.
// Assumes inclusion by smp_port.v only; definitions only.
`ifndef SMP_PORT_REGS_VH
`define SMP_PORT_REGS_VH
`define SMP_OFF_DATA     12'h000
`define SMP_OFF_CTRL     12'h004
`define SMP_OFF_STAT     12'h008
`define SMP_OFF_DIV      12'h00c
`define SMP_OFF_EN       12'h010
`define SMP_OFF_DLY      12'h014
`define SMP_OFF_IRQ_CLR  12'h018
`define SMP_OFF_IRQ_STAT 12'h01c
`define SMP_RST_RXDATA   17'h00000
`define SMP_RST_CTRL     19'h01020
`define SMP_RST_DIV      32'h000000ff
`define SMP_RST_EN       32'h00000000
`define SMP_RST_DLY      32'h00010101
`define SMP_CR_TX_CLR    20
`define SMP_CR_RX_CLR    19
`define SMP_CR_FORCE_MD  13
`define SMP_CR_FORCE_LVL 12
`define SMP_CR_LOOPBACK  11
`define SMP_CR_SEL_MASK  10
`define SMP_CR_SEL_OE    9
`define SMP_CR_SEL_POL   8
`define SMP_CR_MASTER    5
`define SMP_CR_MSB_FIRST 4
`define SMP_CR_PHASE     3
`define SMP_CR_POLARITY  2
`define SMP_SR_TX_DMA    9
`define SMP_SR_RX_DMA    8
`define SMP_SR_SEL_EDGE  6
`define SMP_SR_SEL_ON    5
`define SMP_SR_OVERRUN   4
`define SMP_SR_UNDERRUN  3
`define SMP_SR_TX_IDLE   2
`define SMP_SR_TX_READY  1
`define SMP_SR_RX_READY  0
`define SMP_SR_W1C_MASK  10'h358
`define SMP_IRQ_RX       0
`define SMP_IRQ_TX       1
`define SMP_IRQ_SEL      2
`define SMP_IRQ_RX_DMA   3
`define SMP_IRQ_TX_DMA   4
`define SMP_RESP_OKAY    2'b00
`define SMP_RESP_SLVERR  2'b10
`endif

// file: smp_port.v
// Serial peripheral port, master or slave, with an AXI4-Lite register slave.
// Assumes pins are resolved outside from the _o/_oe pairs; DMA handshake on aclk.
`timescale 1ns/1ns
`include "smp_port_regs.vh"

// Function
// R1: Port runs as clock-generating master or as slave following external clock.
// R2: Four lines only: select, serial clock, master-out data, master-in data.
// R3: Master drives master-out and samples master-in; slave does the reverse.
// R4: Select and clock pins drive as master, are inputs as slave; select drives only while control bit 9 is set.
// R5: Frames carry 8, 9, 16 or 17 bits; both sides agree on width.
// R6: Software programs clock idle polarity and sampling phase.
// R7: Master inserts start, burst and stop delays; delay register resets 0x010101.
// R8: Offset 0x00 write loads transmit data; read returns receive data, reset zero.
// R9: Transmit and receive data registers hold 17 bits.
// R10: Control holds configuration bits; reset 0x001020 gives master, select high.
// R11: Divider sets master clock rate from peripheral clock; resets to 0xff.
// R12: Control 0x04, status 0x08, enable 0x10, delay 0x14 decoded in window.
// R13: Writing one to buffer-clear bits empties that buffer; zero does nothing.
// R14: Five enable bits gate transmit, receive, DMA done and select-edge interrupts.
// R15: No serial transfer while enable register is clear; it resets to zero.
// R16: Control bit 5 selects slave when 0, master when 1.
// R17: Polarity equal to phase samples on rising edge; otherwise on falling.
// R18: Width field 00=8, 01=9, 10=16, 11=17 bits.
// R19: Loop-back bit in master mode returns transmitted data to the receiver.
module smp_port (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        select_pin_i,
  output reg         select_pin_o,
  output wire        select_pin_oe,
  input  wire        serial_clock_pin_i,
  output reg         serial_clock_pin_o,
  output wire        serial_clock_pin_oe,
  input  wire        master_out_pin_i,
  output wire        master_out_pin_o,
  output wire        master_out_pin_oe,
  input  wire        master_in_pin_i,
  output wire        master_in_pin_o,
  output wire        master_in_pin_oe,
  output wire        tx_dma_req,
  output wire        rx_dma_req,
  input  wire        tx_dma_done,
  input  wire        rx_dma_done,
  output wire        irq
);

  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_START = 3'd1;
  localparam [2:0] ST_SHIFT = 3'd2;
  localparam [2:0] ST_BURST = 3'd3;
  localparam [2:0] ST_STOP  = 3'd4;

  reg  [11:0] aw_addr_reg;
  reg         aw_full_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_full_reg;
  reg  [18:0] port_control_reg;
  reg  [31:0] clock_divider_reg;
  reg  [31:0] port_enable_reg;
  reg  [31:0] delay_length_reg;
  reg  [9:0]  flag_reg;
  reg  [4:0]  irq_stat_reg;
  reg  [16:0] transmit_data_reg;
  reg  [16:0] receive_data_reg;
  reg         tx_full_reg;
  reg         rx_full_reg;
  reg  [16:0] tx_sh_reg;
  reg  [16:0] rx_sh_reg;
  reg  [4:0]  bit_cnt_reg;
  reg  [5:0]  edge_cnt_reg;
  reg  [15:0] div_cnt_reg;
  reg  [7:0]  dly_cnt_reg;
  reg  [2:0]  state_reg;
  reg         next_ld_reg;
  reg  [3:0]  sync1_reg;
  reg  [3:0]  sync2_reg;
  reg  [3:0]  sync3_reg;
  reg  [3:0]  filt_reg;
  reg         sclk_prev_reg;
  reg         sel_prev_reg;
  reg         sel_act_prev_reg;
  reg  [31:0] rd_mux;
  reg         rd_hit;

  wire        enabled     = port_enable_reg[0];
  wire        master      = port_control_reg[`SMP_CR_MASTER];                    // R16
  wire        msb_first   = port_control_reg[`SMP_CR_MSB_FIRST];
  wire        cpha        = port_control_reg[`SMP_CR_PHASE];
  wire        cpol        = port_control_reg[`SMP_CR_POLARITY];
  wire        sel_pol     = port_control_reg[`SMP_CR_SEL_POL];
  wire [1:0]  frame_width_sel = port_control_reg[1:0];
  wire        sel_f       = filt_reg[3];
  wire        sclk_f      = filt_reg[2];
  wire        mosi_f      = filt_reg[1];
  wire        miso_f      = filt_reg[0];
  wire [31:0] wmask       = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  wire        wr_go       = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  wire        rd_go       = s_axi_arvalid & ~s_axi_rvalid;
  wire        wr_hit      = (aw_addr_reg[11:5] == 7'h00) & (aw_addr_reg[1:0] == 2'b00);
  reg  [4:0]  nbits;

  always @*
  begin
    case (frame_width_sel)                                                     // R18
      2'b00:   nbits = 5'd8;
      2'b01:   nbits = 5'd9;
      2'b10:   nbits = 5'd16;
      default: nbits = 5'd17;
    endcase
  end

  wire [16:0] fmask      = ~(17'h1ffff << nbits);
  wire        out_bit    = msb_first ? tx_sh_reg[nbits - 5'd1] : tx_sh_reg[0];
  // Slave select is honoured only when not masked; masking keeps an enabled slave live without a select
  wire        sel_active = port_control_reg[`SMP_CR_SEL_MASK] | (sel_f == sel_pol);
  wire        slave_live = enabled & ~master & sel_active;
  wire        tick       = (div_cnt_reg >= clock_divider_reg[15:0]);             // R11
  wire        m_edge     = enabled & master & (state_reg == ST_SHIFT) & tick;
  wire        s_edge     = slave_live & (sclk_f ^ sclk_prev_reg);
  wire        edge_ev    = m_edge | s_edge;
  wire        edge_rise  = master ? ~serial_clock_pin_o : sclk_f;
  wire        is_sample  = (edge_rise == (cpol == cpha));                        // R17
  wire        in_bit     = master ? (port_control_reg[`SMP_CR_LOOPBACK] ? out_bit : miso_f) : mosi_f; // R19 R3
  wire [16:0] rx_new     = msb_first ? {rx_sh_reg[15:0], in_bit} :
                           (((rx_sh_reg & fmask) >> 1) | ({16'h0000, in_bit} << (nbits - 5'd1)));
  wire        frame_done = edge_ev & is_sample & ((bit_cnt_reg + 5'd1) == nbits); // R5
  wire        load_next  = frame_done & tx_full_reg;
  wire        tx_idle    = ~tx_full_reg & (master ? (state_reg == ST_IDLE) : ~sel_active);
  wire        sel_on     = master ? (state_reg != ST_IDLE) : sel_active;
  wire [9:0]  status_view = flag_reg | {4'h0, sel_on, 2'b00, tx_idle, ~tx_full_reg, rx_full_reg};

  assign s_axi_awready       = ~aw_full_reg;
  assign s_axi_wready        = ~w_full_reg;
  assign s_axi_arready       = ~s_axi_rvalid;
  assign serial_clock_pin_oe = master;                                           // R4
  assign select_pin_oe       = master & port_control_reg[`SMP_CR_SEL_OE];        // R4
  assign master_out_pin_o    = out_bit;
  assign master_out_pin_oe   = master & enabled;                                 // R3
  assign master_in_pin_o     = out_bit;
  assign master_in_pin_oe    = slave_live;                                       // R3
  assign tx_dma_req          = enabled & ~tx_full_reg;
  assign rx_dma_req          = rx_full_reg;
  assign irq                 = |(irq_stat_reg & port_control_reg[18:14]);        // R14

  always @*
  begin
    rd_hit = (s_axi_araddr[11:5] == 7'h00) & (s_axi_araddr[1:0] == 2'b00);
    case (s_axi_araddr[11:0])
      `SMP_OFF_DATA:     rd_mux = {15'h0000, receive_data_reg};                  // R8
      `SMP_OFF_CTRL:     rd_mux = {13'h0000, port_control_reg};
      `SMP_OFF_STAT:     rd_mux = {22'h000000, status_view};
      `SMP_OFF_DIV:      rd_mux = clock_divider_reg;
      `SMP_OFF_EN:       rd_mux = port_enable_reg;
      `SMP_OFF_DLY:      rd_mux = delay_length_reg;
      `SMP_OFF_IRQ_STAT: rd_mux = {27'h0000000, irq_stat_reg};
      default:
      begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
    if (s_axi_araddr[11:0] == `SMP_OFF_IRQ_CLR)
    begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_addr_reg        <= 12'h000;
      aw_full_reg        <= 1'b0;
      w_data_reg         <= 32'h00000000;
      w_strb_reg         <= 4'h0;
      w_full_reg         <= 1'b0;
      s_axi_bvalid       <= 1'b0;
      s_axi_bresp        <= `SMP_RESP_OKAY;
      s_axi_rvalid       <= 1'b0;
      s_axi_rresp        <= `SMP_RESP_OKAY;
      s_axi_rdata        <= 32'h00000000;
      port_control_reg   <= `SMP_RST_CTRL;                                       // R10
      clock_divider_reg  <= `SMP_RST_DIV;                                        // R11
      port_enable_reg    <= `SMP_RST_EN;                                         // R15
      delay_length_reg   <= `SMP_RST_DLY;                                        // R7
      flag_reg           <= 10'h000;
      irq_stat_reg       <= 5'h00;
      transmit_data_reg  <= 17'h00000;
      receive_data_reg   <= `SMP_RST_RXDATA;                                     // R8
      tx_full_reg        <= 1'b0;
      rx_full_reg        <= 1'b0;
      tx_sh_reg          <= 17'h00000;
      rx_sh_reg          <= 17'h00000;
      bit_cnt_reg        <= 5'd0;
      edge_cnt_reg       <= 6'd0;
      div_cnt_reg        <= 16'h0000;
      dly_cnt_reg        <= 8'h00;
      state_reg          <= ST_IDLE;
      next_ld_reg        <= 1'b0;
      sync1_reg          <= 4'h0;
      sync2_reg          <= 4'h0;
      sync3_reg          <= 4'h0;
      filt_reg           <= 4'h0;
      sclk_prev_reg      <= 1'b0;
      sel_prev_reg       <= 1'b0;
      sel_act_prev_reg   <= 1'b0;
      serial_clock_pin_o <= 1'b0;
      select_pin_o       <= 1'b1;
    end
    else
    begin
      // Pin inputs settle only when the last two stages agree, which rejects one-cycle glitches
      sync1_reg <= {select_pin_i, serial_clock_pin_i, master_out_pin_i, master_in_pin_i};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= (filt_reg & (sync2_reg ^ sync3_reg)) | (sync3_reg & ~(sync2_reg ^ sync3_reg));
      sclk_prev_reg    <= sclk_f;
      sel_prev_reg     <= sel_f;
      sel_act_prev_reg <= sel_active;

      if (s_axi_awvalid && !aw_full_reg)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr[11:0];
      end
      if (s_axi_wvalid && !w_full_reg)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_hit && aw_addr_reg != `SMP_OFF_IRQ_STAT) ? `SMP_RESP_OKAY : `SMP_RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_hit ? `SMP_RESP_OKAY : `SMP_RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end

      // Clears come first so that a hardware set later in this block wins the same cycle
      if (rd_go && s_axi_araddr[11:0] == `SMP_OFF_DATA)
      begin
        rx_full_reg                <= 1'b0;
        flag_reg[`SMP_SR_OVERRUN]  <= 1'b0;
      end
      if (wr_go && aw_addr_reg == `SMP_OFF_STAT)
      begin
        flag_reg <= flag_reg & ~(w_data_reg[9:0] & `SMP_SR_W1C_MASK);
      end
      if (wr_go && aw_addr_reg == `SMP_OFF_IRQ_CLR)
      begin
        irq_stat_reg <= irq_stat_reg & ~w_data_reg[4:0];
      end
      if (wr_go && aw_addr_reg == `SMP_OFF_CTRL && w_strb_reg[2] && w_data_reg[`SMP_CR_RX_CLR])
      begin
        rx_full_reg <= 1'b0;                                                     // R13
      end

      if (tx_dma_done)
      begin
        flag_reg[`SMP_SR_TX_DMA]    <= 1'b1;
        irq_stat_reg[`SMP_IRQ_TX_DMA] <= 1'b1;
      end
      if (rx_dma_done)
      begin
        flag_reg[`SMP_SR_RX_DMA]    <= 1'b1;
        irq_stat_reg[`SMP_IRQ_RX_DMA] <= 1'b1;
      end
      if (!master && sel_f != sel_prev_reg)
      begin
        flag_reg[`SMP_SR_SEL_EDGE]  <= 1'b1;
        irq_stat_reg[`SMP_IRQ_SEL]  <= 1'b1;
      end

      // Slave: present the first bit as soon as it is selected
      if (!master && !sel_active)
      begin
        bit_cnt_reg <= 5'd0;
      end
      else if (slave_live && !sel_act_prev_reg)
      begin
        bit_cnt_reg <= 5'd0;
        if (tx_full_reg)
        begin
          tx_sh_reg                <= transmit_data_reg;
          tx_full_reg              <= 1'b0;
          irq_stat_reg[`SMP_IRQ_TX] <= 1'b1;
        end
        else
        begin
          flag_reg[`SMP_SR_UNDERRUN] <= 1'b1;
        end
      end

      if (edge_ev)                                                               // R6
      begin
        if (is_sample)
        begin
          rx_sh_reg <= rx_new;
          if (frame_done)
          begin
            receive_data_reg          <= rx_new & fmask;                         // R9
            rx_full_reg               <= 1'b1;
            irq_stat_reg[`SMP_IRQ_RX] <= 1'b1;
            bit_cnt_reg               <= 5'd0;
            if (rx_full_reg)
            begin
              flag_reg[`SMP_SR_OVERRUN] <= 1'b1;
            end
            next_ld_reg <= load_next;
            if (load_next)
            begin
              tx_sh_reg                 <= transmit_data_reg;
              tx_full_reg               <= 1'b0;
              irq_stat_reg[`SMP_IRQ_TX] <= 1'b1;
            end
            else if (!master)
            begin
              flag_reg[`SMP_SR_UNDERRUN] <= 1'b1;
            end
          end
          else
          begin
            bit_cnt_reg <= bit_cnt_reg + 5'd1;
          end
        end
        else if (bit_cnt_reg != 5'd0)
        begin
          // No shift before the first sample, so phase 1 keeps its first bit for one edge
          tx_sh_reg <= msb_first ? {tx_sh_reg[15:0], 1'b0} : {1'b0, tx_sh_reg[16:1]};
        end
      end

      div_cnt_reg <= (state_reg == ST_IDLE || tick) ? 16'h0000 : div_cnt_reg + 16'h0001;
      case (state_reg)                                                           // R1
        ST_IDLE:
        begin
          serial_clock_pin_o <= cpol;
          edge_cnt_reg       <= 6'd0;
          if (enabled && master && tx_full_reg)                                  // R15
          begin
            state_reg                 <= ST_START;
            dly_cnt_reg               <= delay_length_reg[7:0];                  // R7
            tx_sh_reg                 <= transmit_data_reg;
            tx_full_reg               <= 1'b0;
            irq_stat_reg[`SMP_IRQ_TX] <= 1'b1;
            bit_cnt_reg               <= 5'd0;
          end
        end
        ST_START, ST_BURST:
        begin
          if (tick)
          begin
            if (dly_cnt_reg == 8'h00)
            begin
              state_reg <= ST_SHIFT;
            end
            else
            begin
              dly_cnt_reg <= dly_cnt_reg - 8'h01;
            end
          end
        end
        ST_SHIFT:
        begin
          if (tick)
          begin
            serial_clock_pin_o <= ~serial_clock_pin_o;
            edge_cnt_reg       <= edge_cnt_reg + 6'd1;
            if ((edge_cnt_reg + 6'd1) == {nbits, 1'b0})
            begin
              edge_cnt_reg <= 6'd0;
              if (next_ld_reg || load_next)
              begin
                state_reg   <= ST_BURST;
                dly_cnt_reg <= delay_length_reg[15:8];                           // R7
              end
              else
              begin
                state_reg   <= ST_STOP;
                dly_cnt_reg <= delay_length_reg[23:16];                          // R7
              end
            end
          end
        end
        ST_STOP:
        begin
          if (tick)
          begin
            if (dly_cnt_reg == 8'h00)
            begin
              state_reg <= ST_IDLE;
            end
            else
            begin
              dly_cnt_reg <= dly_cnt_reg - 8'h01;
            end
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
      if (!enabled || !master)
      begin
        state_reg <= ST_IDLE;                                                    // R15
      end
      if (port_control_reg[`SMP_CR_FORCE_MD])
      begin
        select_pin_o <= port_control_reg[`SMP_CR_FORCE_LVL];
      end
      else
      begin
        select_pin_o <= (state_reg != ST_IDLE) ? sel_pol : ~sel_pol;             // R2
      end

      // Register writes last: a new transmit word and the transmit buffer clear win over the engine
      if (wr_go)
      begin
        case (aw_addr_reg)
          `SMP_OFF_DATA:                                                         // R8
          begin
            transmit_data_reg <= (transmit_data_reg & ~wmask[16:0]) | (w_data_reg[16:0] & wmask[16:0]);
            tx_full_reg       <= 1'b1;
          end
          `SMP_OFF_CTRL:                                                         // R12
          begin
            port_control_reg <= (port_control_reg & ~wmask[18:0]) | (w_data_reg[18:0] & wmask[18:0]);
            if (w_strb_reg[2] && w_data_reg[`SMP_CR_TX_CLR])
            begin
              tx_full_reg <= 1'b0;                                               // R13
            end
          end
          `SMP_OFF_DIV: clock_divider_reg <= (clock_divider_reg & ~wmask) | (w_data_reg & wmask);
          `SMP_OFF_EN:  port_enable_reg   <= (port_enable_reg & ~wmask) | (w_data_reg & wmask);
          `SMP_OFF_DLY: delay_length_reg  <= (delay_length_reg & ~wmask) | (w_data_reg & wmask);
          default:
          begin
            transmit_data_reg <= transmit_data_reg;
          end
        endcase
      end
    end
  end

endmodule // smp_port

// file: smp_port_props.sv
// Assertions on the register slave handshakes and the pin drive enables.
// Bound to smp_port; watches its ports only.
`timescale 1ns/1ns
module smp_port_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        select_pin_oe,
  input wire        serial_clock_pin_oe,
  input wire        master_out_pin_oe,
  input wire        master_in_pin_oe
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_b_latency: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_r_latency: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
  chk_aw_drop: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address taken twice");
  chk_ar_gate: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read ready wrong");
  chk_sel_master: assert property (select_pin_oe |-> serial_clock_pin_oe)
    else $error("select driven as slave");
  chk_mo_master: assert property (master_out_pin_oe |-> serial_clock_pin_oe)
    else $error("master out driven as slave");
  chk_mi_slave: assert property (master_in_pin_oe |-> !serial_clock_pin_oe)
    else $error("master in driven as master");
endmodule // smp_port_props
bind smp_port smp_port_props u_props (.*);

// file: smp_peer.sv
// Behavioural external slave: clock mode 0, MSB first.
// Select is active low; the data line is inverted when select is released.
`timescale 1ns/1ns
module smp_peer #(
  parameter [16:0] PAT = 17'h1a5c3
) (
  input  wire        sel_n,
  input  wire        sclk,
  input  wire        mosi,
  output reg         miso,
  output reg  [16:0] got
);
  reg [16:0] sh;
  initial
  begin
    miso = 1'b0;
    got = 17'h0;
    sh = 17'h0;
  end
  always @(negedge sel_n)
  begin
    sh = PAT;
    got = 17'h0;
    miso = PAT[16];
  end
  always @(posedge sclk)
    if (!sel_n)
      got = {got[15:0], mosi};
  always @(negedge sclk)
    if (!sel_n)
    begin
      sh = sh << 1;
      miso = sh[16];
    end
  // Inverted on release so a stale bit cannot pass for data
  always @(posedge sel_n)
    miso = ~miso;
endmodule // smp_peer

// file: smp_port_test.sv
// Bench for smp_port: reset values, interrupt gating, master frames.
// Acts as AXI4-Lite master; smp_peer stands at the pins as slave.
`timescale 1ns/1ns
module smp_port_test;
  localparam [16:0] PAT = 17'h1a5c3;
  reg         aclk = 1'b0, aresetn = 1'b0;
  reg  [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  reg  [3:0]  s_axi_wstrb = 4'hf;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg         tx_dma_done = 1'b0, rx_dma_done = 1'b0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        select_pin_o, select_pin_oe, serial_clock_pin_o, serial_clock_pin_oe;
  wire        master_out_pin_o, master_out_pin_oe, master_in_pin_o, master_in_pin_oe;
  wire        tx_dma_req, rx_dma_req, irq, peer_miso;
  wire [16:0] peer_got;
  // Select line has a pull-up; the clock line idles low when undriven
  wire        select_pin_i = select_pin_oe ? select_pin_o : 1'b1;
  wire        serial_clock_pin_i = serial_clock_pin_oe ? serial_clock_pin_o : 1'b0;
  wire        master_out_pin_i = master_out_pin_o;
  wire        master_in_pin_i = master_in_pin_oe ? master_in_pin_o : peer_miso;
  integer     fails = 0, n_checks = 0;
  smp_port dut (.*);
  smp_peer #(.PAT(PAT)) peer (.sel_n(select_pin_i), .sclk(serial_clock_pin_i),
    .mosi(master_out_pin_i), .miso(peer_miso), .got(peer_got));
  always #10 aclk = ~aclk;
  task finish_test;
    begin
      if (fails == 0 && n_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task check(input [31:0] s, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e)
      begin
        fails = fails + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    begin
      s_axi_awaddr <= {20'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do
      begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      check({30'h0, s_axi_bresp}, 32'h0);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
    end
  endtask
  task rc(input [11:0] a, input [31:0] e, input [1:0] er);
    begin
      s_axi_araddr <= {20'h0, a};
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      check(s_axi_rdata, e);
      check({30'h0, s_axi_rresp}, {30'h0, er});
      s_axi_rready <= 1'b0;
    end
  endtask
  task irq_gate;
    begin
      rx_dma_done <= 1'b1;
      @(posedge aclk);
      rx_dma_done <= 1'b0;
      repeat (3) @(posedge aclk);
      check(irq, 32'h0);
      rc(12'h01c, 32'h8, 2'b00);
      rc(12'h008, 32'h106, 2'b00);
      wr(12'h004, 32'h21020);
      check(irq, 32'h1);
      wr(12'h018, 32'h8);
      check(irq, 32'h0);
      wr(12'h000, 32'h5);
      rc(12'h008, 32'h100, 2'b00);
      wr(12'h004, 32'h101020);
      rc(12'h008, 32'h106, 2'b00);
    end
  endtask
  // One master frame; w is the width code, m is {phase, polarity}; loop-back frames go LSB first
  task xfer(input [1:0] w, input [1:0] m, input lb, input [16:0] tx);
    integer i, n;
    reg [31:0] mk;
    begin
      n = (w == 2'd0) ? 8 : (w == 2'd1) ? 9 : (w == 2'd2) ? 16 : 17;
      mk = (32'h1 << n) - 32'h1;
      wr(12'h004, 32'h4220 | ({31'h0, lb} << 11) | ({31'h0, !lb} << 4) | ({30'h0, m} << 2) | {30'h0, w});
      wr(12'h010, 32'h1);
      wr(12'h000, {15'h0, tx});
      for (i = 0; i < 400 && irq !== 1'b1; i = i + 1) @(posedge aclk);
      check(irq, 32'h1);
      rc(12'h000, lb ? ({15'h0, tx} & mk) : ({15'h0, PAT} >> (17 - n)), 2'b00);
      if (!lb) check({15'h0, peer_got} & mk, {15'h0, tx} & mk);
      check({28'h0, tx_dma_req, rx_dma_req, master_out_pin_oe, master_in_pin_oe}, 32'ha);
      // The select only returns high once the stop delay has run out
      for (i = 0; i < 200 && select_pin_o !== 1'b1; i = i + 1) @(posedge aclk);
      check(select_pin_o, 32'h1);
      check(serial_clock_pin_o, {31'h0, m[0]});
      wr(12'h018, 32'h1);
    end
  endtask
  initial
  begin
    #200000;
    fails = fails + 1;
    finish_test;
  end
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rc(12'h000, 32'h0, 2'b00);
    rc(12'h004, 32'h1020, 2'b00);
    rc(12'h008, 32'h6, 2'b00);
    rc(12'h00c, 32'hff, 2'b00);
    rc(12'h010, 32'h0, 2'b00);
    rc(12'h014, 32'h10101, 2'b00);
    rc(12'h020, 32'h0, 2'b10);
    irq_gate;
    // Half period must cover the four-clock input synchroniser on the returning data
    wr(12'h00c, 32'h5);
    xfer(2'd0, 2'd0, 1'b0, 17'h000a5);
    xfer(2'd1, 2'd0, 1'b0, 17'h00155);
    xfer(2'd2, 2'd0, 1'b0, 17'h0beef);
    xfer(2'd3, 2'd0, 1'b0, 17'h1cafe);
    xfer(2'd3, 2'd1, 1'b1, 17'h13579);
    xfer(2'd2, 2'd2, 1'b1, 17'h0a5a5);
    xfer(2'd1, 2'd3, 1'b1, 17'h0012c);
    finish_test;
  end
endmodule // smp_port_test
